// [core/pport_pkg.sv]
// constants, types and layouts shared by the dual parallel port design.
// assumes a single system clock; nothing here holds logic.
package pport_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned SYNC_W     = 2;

  // operating modes, two bits taken from the mode control word
  localparam logic [1:0] MODE_OUT   = 2'h0;
  localparam logic [1:0] MODE_IN    = 2'h1;
  localparam logic [1:0] MODE_BIDIR = 2'h2;
  localparam logic [1:0] MODE_BIT   = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_IN;

  // command word decode: low nibble selects the word kind
  localparam logic [3:0] CMD_MODE_KEY  = 4'hf;
  localparam logic [3:0] CMD_INTC_KEY  = 4'h7;
  localparam logic [3:0] CMD_INTEN_KEY = 4'h3;
  localparam int unsigned CMD_MODE_LSB  = 6;
  localparam int unsigned CMD_IE_BIT    = 7;
  localparam int unsigned CMD_MASKF_BIT = 4;

  // opcode bytes watched on the data bus during fetches
  localparam logic [7:0] RET_PREFIX_OPCODE       = 8'hed;
  localparam logic [7:0] interrupt_return_opcode = 8'h4d;

  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] VEC_RESET = 8'h00;

  // which follow-on word a port is waiting for
  typedef enum logic [1:0] {
    EXP_NONE = 2'b00,
    EXP_DIR  = 2'b01,
    EXP_MASK = 2'b11
  } expect_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] vector;
    logic       ie;
    logic [7:0] dir;
    expect_type expect_word;
    logic [7:0] out_reg;
    logic [7:0] in_reg;
    logic       in_full;
    logic       out_ready;
    logic       pend;
    logic       serv;
  } port_type;

endpackage

// [core/strobe_sync.sv]
// two-flop synchroniser for the peripheral strobes.
// assumes strobes idle high; stage one feeds stage two only.
`timescale 1ns/1ps
`default_nettype none
module strobe_sync
  import pport_pkg::*;
#(
  parameter int unsigned WIDTH = SYNC_W
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // strobes
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule
`default_nettype wire

// [core/byte_fifo.sv]
// small synchronous fifo with valid/ready on both sides.
// assumes one clock; push on full and pop on empty are refused.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_ff != DEPTH[AW:0]);
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = mem[rd_ptr_ff];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule
`default_nettype wire

// [core/dual_parallel_port.sv]
// dual 8-bit parallel port with handshake behind a processor io bus.
// assumes bus inputs synchronous to CLK_SYS_IN; strobes are resynced.
`timescale 1ns/1ps
`default_nettype none
module dual_parallel_port
  import pport_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_SYS_IN,
  input  wire logic       RESET_IN,
  // processor bus
  input  wire logic       CE_N_IN,
  input  wire logic       PORT_SEL_IN,
  input  wire logic       CTRL_SEL_IN,
  input  wire logic       RD_N_IN,
  input  wire logic       IO_CYCLE_N_IN,
  input  wire logic       OPCODE_FETCH_N_IN,
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_N_OUT,
  // interrupt daisy chain
  input  wire logic       PRIORITY_IN,
  output logic            PRIORITY_OUT,
  output logic            INT_N_OUT,
  output logic            INT_OE_N_OUT,
  // port A
  input  wire logic [7:0] PORT_A_IN,
  output logic      [7:0] PORT_A_OUT,
  output logic      [7:0] PORT_A_OE_N_OUT,
  output logic            PORT_A_READY_OUT,
  input  wire logic       PORT_A_STROBE_N_IN,
  output logic            PORT_A_TX_SPACE_OUT,
  // port B
  input  wire logic [7:0] PORT_B_IN,
  output logic      [7:0] PORT_B_OUT,
  output logic      [7:0] PORT_B_OE_N_OUT,
  output logic            PORT_B_READY_OUT,
  input  wire logic       PORT_B_STROBE_N_IN
);

  typedef struct packed {
    port_type   a;
    port_type   b;
    logic [1:0] prev_stb;
    logic       prev_wr;
    logic       prev_rd;
    logic       prev_ack;
    logic       prev_fetch;
    logic       prev_lone;
    logic       int_gate;
    logic       seen_prefix;
    logic [7:0] fetch_byte;
    logic [7:0] data_out;
    logic       data_oe_n;
  } state_type;

  function automatic port_type port_reset();
    port_type p;
    p             = '0;
    p.mode        = MODE_RESET;
    p.vector      = VEC_RESET;
    p.dir         = DIR_RESET;
    p.expect_word = EXP_NONE;
    return p;
  endfunction

  function automatic state_type state_reset();
    state_type s;
    s           = '0;
    s.a         = port_reset();
    s.b         = port_reset();
    s.prev_stb  = '1;
    s.data_oe_n = 1'b1;
    return s;
  endfunction

  localparam state_type ST_RESET = state_reset();

  // command word handling, shared by both ports
  function automatic port_type apply_cmd(port_type p, logic [7:0] d);
    port_type q;
    q = p;
    if (p.expect_word == EXP_DIR) begin
      q.dir         = d;
      q.expect_word = EXP_NONE;
    end else if (p.expect_word == EXP_MASK) begin
      q.expect_word = EXP_NONE;
    end else if (!d[0]) begin
      q.vector = {d[7:1], 1'b0};
    end else if (d[3:0] == CMD_MODE_KEY) begin
      q.mode      = d[CMD_MODE_LSB +: 2];
      q.out_ready = 1'b0;
      q.in_full   = 1'b0;
      if (d[CMD_MODE_LSB +: 2] == MODE_BIT) begin
        q.expect_word = EXP_DIR;
      end
    end else if (d[3:0] == CMD_INTC_KEY) begin
      q.ie = d[CMD_IE_BIT];
      if (d[CMD_MASKF_BIT]) begin
        q.expect_word = EXP_MASK;
      end
    end else if (d[3:0] == CMD_INTEN_KEY) begin
      q.ie = d[CMD_IE_BIT];
    end
    return q;
  endfunction

  // bit mode read mixes output bits and live input bits
  function automatic logic [7:0] read_val(port_type p, logic [7:0] pins);
    logic [7:0] v;
    v = p.in_reg;
    if (p.mode == MODE_OUT) begin
      v = p.out_reg;
    end else if (p.mode == MODE_BIT) begin
      v = (p.out_reg & ~p.dir) | (pins & p.dir);
    end
    return v;
  endfunction

  state_type  st_ff;
  state_type  nxt_st;
  logic [1:0] stb_sync;
  logic       wr_cond;
  logic       rd_cond;
  logic       ack_cond;
  logic       fetch_cond;
  logic       lone_cond;
  logic       wr_pulse;
  logic       rd_end;
  logic       a_rise;
  logic       b_rise;
  logic       a_bidir;
  logic       fifo_valid;
  logic       fifo_pop;
  logic       fifo_push;
  logic [7:0] fifo_data;
  logic       int_req;

  strobe_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_in   (CLK_SYS_IN),
    .reset_in (RESET_IN),
    .async_in ({PORT_B_STROBE_N_IN, PORT_A_STROBE_N_IN}),
    .sync_out (stb_sync)
  );

  // port A output data queues here; the peripheral's pace drains it
  byte_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLK_SYS_IN),
    .reset_in      (RESET_IN),
    .in_valid_in   (fifo_push),
    .in_ready_out  (PORT_A_TX_SPACE_OUT),
    .in_data_in    (DATA_IN),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  assign rd_cond    = !CE_N_IN && !IO_CYCLE_N_IN && !RD_N_IN
                      && OPCODE_FETCH_N_IN;
  assign wr_cond    = !CE_N_IN && !IO_CYCLE_N_IN && RD_N_IN
                      && OPCODE_FETCH_N_IN;
  assign ack_cond   = !IO_CYCLE_N_IN && !OPCODE_FETCH_N_IN;
  assign fetch_cond = !OPCODE_FETCH_N_IN && !RD_N_IN && IO_CYCLE_N_IN;
  assign lone_cond  = !OPCODE_FETCH_N_IN && RD_N_IN && IO_CYCLE_N_IN;
  assign wr_pulse   = wr_cond && !st_ff.prev_wr;
  assign rd_end     = st_ff.prev_rd && !rd_cond;
  assign a_rise     = stb_sync[0] && !st_ff.prev_stb[0];
  assign b_rise     = stb_sync[1] && !st_ff.prev_stb[1];
  assign a_bidir    = (st_ff.a.mode == MODE_BIDIR);
  assign fifo_push  = wr_pulse && !CTRL_SEL_IN && !PORT_SEL_IN
                      && (st_ff.a.mode == MODE_OUT || a_bidir);
  assign fifo_pop   = fifo_valid && !st_ff.a.out_ready
                      && (st_ff.a.mode == MODE_OUT || a_bidir);

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.prev_stb   = stb_sync;
    nxt_st.prev_wr    = wr_cond;
    nxt_st.prev_rd    = rd_cond;
    nxt_st.prev_ack   = ack_cond;
    nxt_st.prev_fetch = fetch_cond;
    nxt_st.prev_lone  = lone_cond;

    // acknowledge and return clears come before the strobe sets below, so a same-cycle set wins
    // watch fetched opcodes for the two-byte return
    if (fetch_cond) begin
      nxt_st.fetch_byte = DATA_IN;
    end
    if (st_ff.prev_fetch && !fetch_cond) begin
      nxt_st.seen_prefix = (st_ff.fetch_byte == RET_PREFIX_OPCODE);
      if (st_ff.seen_prefix && PRIORITY_IN
          && st_ff.fetch_byte == interrupt_return_opcode) begin
        if (st_ff.a.serv) begin
          nxt_st.a.serv = 1'b0;
        end else begin
          nxt_st.b.serv = 1'b0;
        end
      end
    end

    // interrupt acknowledge: A first inside the device
    if (ack_cond && !st_ff.prev_ack && PRIORITY_IN && st_ff.int_gate) begin
      if (st_ff.a.pend) begin
        nxt_st.a.pend = 1'b0;
        nxt_st.a.serv = 1'b1;
      end else if (st_ff.b.pend) begin
        nxt_st.b.pend = 1'b0;
        nxt_st.b.serv = 1'b1;
      end
    end

    // port A handshake
    if (st_ff.a.mode == MODE_OUT || a_bidir) begin
      if (fifo_pop) begin
        nxt_st.a.out_reg   = fifo_data;
        nxt_st.a.out_ready = 1'b1;
      end else if (st_ff.a.out_ready && a_rise) begin
        nxt_st.a.out_ready = 1'b0;
        nxt_st.a.pend      = nxt_st.a.pend | st_ff.a.ie;
      end
    end else if (st_ff.a.mode == MODE_IN) begin
      if (!stb_sync[0] && !st_ff.a.in_full) begin
        nxt_st.a.in_reg = PORT_A_IN;
      end
      if (a_rise && !st_ff.a.in_full) begin
        nxt_st.a.in_full = 1'b1;
        nxt_st.a.pend    = nxt_st.a.pend | st_ff.a.ie;
      end
    end

    // port B strobe serves A's input side while A is bidirectional
    if (a_bidir) begin
      if (!stb_sync[1] && !st_ff.a.in_full) begin
        nxt_st.a.in_reg = PORT_A_IN;
      end
      if (b_rise && !st_ff.a.in_full) begin
        nxt_st.a.in_full = 1'b1;
        nxt_st.b.pend    = nxt_st.b.pend | st_ff.b.ie;
      end
    end else if (st_ff.b.mode == MODE_OUT) begin
      if (st_ff.b.out_ready && b_rise) begin
        nxt_st.b.out_ready = 1'b0;
        nxt_st.b.pend      = nxt_st.b.pend | st_ff.b.ie;
      end
    end else if (st_ff.b.mode == MODE_IN) begin
      if (!stb_sync[1] && !st_ff.b.in_full) begin
        nxt_st.b.in_reg = PORT_B_IN;
      end
      if (b_rise && !st_ff.b.in_full) begin
        nxt_st.b.in_full = 1'b1;
        nxt_st.b.pend    = nxt_st.b.pend | st_ff.b.ie;
      end
    end

    // processor writes: commands and data
    if (wr_pulse) begin
      if (CTRL_SEL_IN) begin
        nxt_st.int_gate = 1'b0;
        if (PORT_SEL_IN) begin
          nxt_st.b = apply_cmd(st_ff.b, DATA_IN);
        end else begin
          nxt_st.a = apply_cmd(st_ff.a, DATA_IN);
        end
      end else if (PORT_SEL_IN) begin
        nxt_st.b.out_reg = DATA_IN;
        if (st_ff.b.mode == MODE_OUT) begin
          nxt_st.b.out_ready = 1'b1;
        end
      end else if (st_ff.a.mode == MODE_BIT) begin
        nxt_st.a.out_reg = DATA_IN;
      end
    end

    // end of a data read frees the input register
    if (rd_end && !CTRL_SEL_IN) begin
      // only a full register is freed, so a same-cycle load wins
      if (!PORT_SEL_IN && st_ff.a.in_full
          && (st_ff.a.mode == MODE_IN || a_bidir)) begin
        nxt_st.a.in_full = 1'b0;
      end else if (PORT_SEL_IN && st_ff.b.in_full
                   && st_ff.b.mode == MODE_IN) begin
        nxt_st.b.in_full = 1'b0;
      end
    end

    if (!OPCODE_FETCH_N_IN && !wr_pulse) begin
      nxt_st.int_gate = 1'b1;
    end

    // read and vector data are registered, one cycle behind the bus
    nxt_st.data_oe_n = 1'b1;
    nxt_st.data_out  = st_ff.data_out;
    if (ack_cond && PRIORITY_IN
        && (st_ff.a.pend || st_ff.b.pend || st_ff.a.serv || st_ff.b.serv))
    begin
      nxt_st.data_oe_n = 1'b0;
      nxt_st.data_out  = (st_ff.a.pend || st_ff.a.serv) ? st_ff.a.vector
                                                        : st_ff.b.vector;
    end else if (rd_cond) begin
      nxt_st.data_oe_n = 1'b0;
      nxt_st.data_out  = PORT_SEL_IN ? read_val(st_ff.b, PORT_B_IN)
                                     : read_val(st_ff.a, PORT_A_IN);
    end

    // two sampled cycles of a lone fetch pulse, so bus skew cannot reset
    if (lone_cond && st_ff.prev_lone) begin
      nxt_st = ST_RESET;
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ready outputs per mode
  always_comb begin
    PORT_A_READY_OUT = 1'b0;
    if (st_ff.a.mode == MODE_OUT || a_bidir) begin
      PORT_A_READY_OUT = st_ff.a.out_ready;
    end else if (st_ff.a.mode == MODE_IN) begin
      PORT_A_READY_OUT = !st_ff.a.in_full;
    end
    PORT_B_READY_OUT = 1'b0;
    if (a_bidir) begin
      PORT_B_READY_OUT = !st_ff.a.in_full;
    end else if (st_ff.b.mode == MODE_OUT) begin
      PORT_B_READY_OUT = st_ff.b.out_ready;
    end else if (st_ff.b.mode == MODE_IN) begin
      PORT_B_READY_OUT = !st_ff.b.in_full;
    end
  end

  // port line drivers
  always_comb begin
    PORT_A_OE_N_OUT = '1;
    PORT_B_OE_N_OUT = '1;
    unique case (st_ff.a.mode)
      MODE_OUT:   PORT_A_OE_N_OUT = '0;
      MODE_BIDIR: PORT_A_OE_N_OUT = {8{stb_sync[0]}};
      MODE_BIT:   PORT_A_OE_N_OUT = st_ff.a.dir;
      MODE_IN:    PORT_A_OE_N_OUT = '1;
    endcase
    unique case (st_ff.b.mode)
      MODE_OUT:   PORT_B_OE_N_OUT = '0;
      MODE_BIT:   PORT_B_OE_N_OUT = st_ff.b.dir;
      MODE_BIDIR: PORT_B_OE_N_OUT = '1;
      MODE_IN:    PORT_B_OE_N_OUT = '1;
    endcase
  end

  assign PORT_A_OUT    = st_ff.a.out_reg;
  assign PORT_B_OUT    = st_ff.b.out_reg;
  assign DATA_OUT      = st_ff.data_out;
  assign DATA_OE_N_OUT = st_ff.data_oe_n;

  // lower chain members are blocked while we are in service
  assign PRIORITY_OUT = PRIORITY_IN && !st_ff.a.serv
                        && !st_ff.b.serv;
  assign int_req      = st_ff.int_gate && PRIORITY_IN && !st_ff.a.serv
                        && !st_ff.b.serv
                        && (st_ff.a.pend || st_ff.b.pend);
  assign INT_N_OUT    = 1'b0;
  assign INT_OE_N_OUT = !int_req;

  a_bit_ready_low: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    st_ff.a.mode == MODE_BIT |-> !PORT_A_READY_OUT)
    else $error("port A ready high in bit mode");

  a_out_ready_hold: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (st_ff.b.mode == MODE_OUT && !a_bidir && PORT_B_READY_OUT
     && !b_rise && !lone_cond && !(wr_pulse && CTRL_SEL_IN))
    |=> PORT_B_READY_OUT)
    else $error("output ready dropped without strobe edge");

  a_in_full_drop: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (st_ff.a.mode == MODE_IN && a_rise && PORT_A_READY_OUT && !wr_pulse
     && !lone_cond) |=> !PORT_A_READY_OUT)
    else $error("input ready not dropped after load");

  a_bidir_gate: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (a_bidir && stb_sync[0]) |-> PORT_A_OE_N_OUT == 8'hff)
    else $error("port A driven with strobe high in bidir");

  a_prio_chain: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (ack_cond && !st_ff.prev_ack && PRIORITY_IN && st_ff.int_gate
     && (st_ff.a.pend || st_ff.b.pend)) |=> !PRIORITY_OUT)
    else $error("priority out high while serviced");

  a_write_latch: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (wr_pulse && PORT_SEL_IN && !CTRL_SEL_IN && st_ff.b.mode == MODE_OUT
     && !lone_cond) |=> (PORT_B_OUT == $past(DATA_IN)) && PORT_B_READY_OUT)
    else $error("port B write not latched with ready");

  a_chip_gate: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (CE_N_IN && OPCODE_FETCH_N_IN) |=> DATA_OE_N_OUT)
    else $error("data bus driven without chip select");

  a_lone_reset: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    lone_cond [*2] |=> (st_ff.a.mode == MODE_RESET) && !st_ff.a.serv
                       && !st_ff.b.pend)
    else $error("lone fetch pulse did not reset");

  a_read_rearm: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (rd_end && !CTRL_SEL_IN && !PORT_SEL_IN && st_ff.a.mode == MODE_IN
     && !a_rise && !wr_pulse) |=> PORT_A_READY_OUT)
    else $error("input ready not re-armed after read");

endmodule
`default_nettype wire

// [sim/pport_peer.sv]
// peripheral model for one handshake port: acks bytes, sends bytes.
// assumes ready is sampled on the rising edge of the system clock.
`timescale 1ns/1ps
`default_nettype none
module pport_peer (
  // clock
  input  wire logic       clk_in,
  // handshake
  input  wire logic       ready_in,
  input  wire logic       ack_en_in,
  output logic            strobe_n_out,
  output logic      [7:0] data_out
);
  logic slow;
  initial begin
    strobe_n_out = 1'b1;
    data_out     = 8'h00;
    slow         = 1'b0;
  end
  // alternate prompt and slow acks to vary the ready hold time
  always begin
    @(posedge clk_in);
    if (ack_en_in && ready_in) begin
      repeat (slow ? 7 : 1) @(posedge clk_in);
      strobe_n_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      strobe_n_out <= 1'b1;
      slow = !slow;
      repeat (4) @(posedge clk_in);
    end
  end
  // data kept past the synced strobe rise, then scrambled three cycles after release
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_in);
    data_out     <= b;
    strobe_n_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    strobe_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    data_out <= ~b;
  endtask
endmodule
`default_nettype wire

// [sim/dual_parallel_port_handshake_bench.sv]
// self-checking bench for the dual parallel port, two peer models.
// assumes the bus is driven on rising edges and results settle by fall.
`timescale 1ns/1ps
`default_nettype none
module dual_parallel_port_handshake_bench;
  import pport_pkg::*;
  logic       clk, rst, ce_n, psel, csel, rd_n, io_n, fetch_n, pri_in;
  logic [7:0] din, dout, pa_out, pa_oe_n, pb_out, pb_oe_n, pa_in, pb_in;
  logic       doe_n, pri_out, int_n, int_oe_n, ra, rb, tx_space;
  logic       sa_n, sb_n, ack_a, ack_b, mon_a, mon_b;
  logic       prev_oe, prev_ra, prev_rb;
  logic [7:0] b, last;
  logic [31:0] seed;
  logic [7:0] rd_q[$], qa[$], qb[$];
  int         errors, tests_run, cycles, n;

  dual_parallel_port i_dut (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .CE_N_IN(ce_n),
    .PORT_SEL_IN(psel), .CTRL_SEL_IN(csel), .RD_N_IN(rd_n),
    .IO_CYCLE_N_IN(io_n), .OPCODE_FETCH_N_IN(fetch_n), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE_N_OUT(doe_n), .PRIORITY_IN(pri_in),
    .PRIORITY_OUT(pri_out), .INT_N_OUT(int_n), .INT_OE_N_OUT(int_oe_n),
    .PORT_A_IN(pa_in), .PORT_A_OUT(pa_out), .PORT_A_OE_N_OUT(pa_oe_n),
    .PORT_A_READY_OUT(ra), .PORT_A_STROBE_N_IN(sa_n),
    .PORT_A_TX_SPACE_OUT(tx_space), .PORT_B_IN(pb_in),
    .PORT_B_OUT(pb_out), .PORT_B_OE_N_OUT(pb_oe_n),
    .PORT_B_READY_OUT(rb), .PORT_B_STROBE_N_IN(sb_n));
  pport_peer i_pa (.clk_in(clk), .ready_in(ra), .ack_en_in(ack_a),
    .strobe_n_out(sa_n), .data_out(pa_in));
  pport_peer i_pb (.clk_in(clk), .ready_in(rb), .ack_en_in(ack_b),
    .strobe_n_out(sb_n), .data_out(pb_in));

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic cen, input logic sel, input logic cs,
                        input logic [7:0] d);
    @(posedge clk);
    ce_n <= cen;
    io_n <= 1'b0;
    psel <= sel;
    csel <= cs;
    din  <= d;
    @(posedge clk);
    ce_n <= 1'b1;
    io_n <= 1'b1;
    @(negedge clk);
  endtask
  task automatic bus_rd(input logic sel, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge clk);
    ce_n <= 1'b0;
    io_n <= 1'b0;
    rd_n <= 1'b0;
    psel <= sel;
    csel <= 1'b0;
    repeat (3) @(posedge clk);
    ce_n <= 1'b1;
    io_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic fetch_op(input logic [7:0] op);
    @(posedge clk);
    fetch_n <= 1'b0;
    rd_n    <= 1'b0;
    din     <= op;
    @(posedge clk);
    fetch_n <= 1'b1;
    rd_n    <= 1'b1;
  endtask

  // result watcher: each new result takes the oldest note
  always @(negedge clk) begin
    if (prev_oe && !doe_n) cmp_byte(dout, rd_q.pop_front());
    if (mon_a && ra && !prev_ra) cmp_byte(pa_out, qa.pop_front());
    if (mon_b && rb && !prev_rb) cmp_byte(pb_out, qb.pop_front());
    prev_oe = doe_n;
    prev_ra = ra;
    prev_rb = rb;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    {ce_n, rd_n, io_n, fetch_n, pri_in, prev_oe, rst} = 7'h7f;
    {psel, csel, ack_a, ack_b, mon_a, mon_b, prev_ra, prev_rb} = 8'h00;
    din  = 8'h00;
    seed = 61451;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_bit(ra, 1'b1);
    cmp_bit(doe_n, 1'b1);
    cmp_bit(pri_out, pri_in);
    // port A input handshake and read-back
    b = xs();
    i_pa.send_byte(b);
    @(negedge clk);
    cmp_bit(ra, 1'b0);
    bus_rd(1'b0, b);
    cmp_bit(ra, 1'b1);
    // port B output mode, peer acks
    bus_wr(1'b0, 1'b1, 1'b1, 8'h0f);
    mon_b = 1'b1;
    ack_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      last = xs();
      qb.push_back(last);
      bus_wr(1'b0, 1'b1, 1'b0, last);
      repeat (20) @(negedge clk);
    end
    cmp_bit(qb.size() == 0, 1'b1);
    cmp_byte(pb_oe_n, 8'h00);
    bus_wr(1'b1, 1'b1, 1'b0, ~last);
    cmp_byte(pb_out, last);
    // port A output through the fifo until refused, then drained
    bus_wr(1'b0, 1'b0, 1'b1, 8'h0f);
    mon_a = 1'b1;
    n = 0;
    while (tx_space === 1'b1 && n < 20) begin
      b = xs();
      qa.push_back(b);
      bus_wr(1'b0, 1'b0, 1'b0, b);
      n++;
    end
    cmp_bit(n == FIFO_DEPTH + 1, 1'b1);
    ack_a = 1'b1;
    for (int i = 0; i < 600 && qa.size() > 0; i++) @(negedge clk);
    cmp_bit(qa.size() == 0, 1'b1);
    // port B bit mode: ready low, strobe ignored
    ack_a = 1'b0;
    ack_b = 1'b0;
    mon_b = 1'b0;
    mon_a = 1'b0;
    bus_wr(1'b0, 1'b1, 1'b1, 8'hcf);
    bus_wr(1'b0, 1'b1, 1'b1, 8'h00);
    cmp_bit(rb, 1'b0);
    i_pb.send_byte(8'h5a);
    @(negedge clk);
    cmp_bit(rb, 1'b0);
    bus_rd(1'b1, last);
    // port A bidir, port B bit mode with interrupts enabled, B vector 42
    bus_wr(1'b0, 1'b1, 1'b1, 8'h17);
    bus_wr(1'b0, 1'b1, 1'b1, 8'hff);
    bus_wr(1'b0, 1'b1, 1'b1, 8'h42);
    bus_wr(1'b0, 1'b1, 1'b1, 8'h83);
    bus_wr(1'b0, 1'b0, 1'b1, 8'h8f);
    cmp_bit(rb, 1'b1);
    b = xs();
    qa.push_back(b);
    mon_a = 1'b1;
    bus_wr(1'b0, 1'b0, 1'b0, b);
    repeat (2) @(negedge clk);
    cmp_bit(ra, 1'b1);
    cmp_byte(pa_oe_n, 8'hff);
    ack_a = 1'b1;
    repeat (24) @(negedge clk);
    cmp_bit(ra, 1'b0);
    ack_a = 1'b0;
    mon_a = 1'b0;
    cmp_bit(qa.size() == 0, 1'b1);
    // input side through port B strobe, then acknowledge and return
    fetch_op(8'h00);
    b = xs();
    i_pa.data_out <= b;
    i_pb.send_byte(~b);
    @(negedge clk);
    cmp_bit(rb, 1'b0);
    cmp_bit(int_oe_n, 1'b0);
    cmp_bit(int_n, 1'b0);
    rd_q.push_back(8'h42);
    @(posedge clk);
    io_n    <= 1'b0;
    fetch_n <= 1'b0;
    repeat (2) @(posedge clk);
    io_n    <= 1'b1;
    fetch_n <= 1'b1;
    @(negedge clk);
    cmp_bit(pri_out, 1'b0);
    cmp_bit(int_oe_n, 1'b1);
    bus_rd(1'b0, b);
    cmp_bit(rb, 1'b1);
    fetch_op(RET_PREFIX_OPCODE);
    fetch_op(interrupt_return_opcode);
    repeat (2) @(negedge clk);
    cmp_bit(pri_out, 1'b1);
    // lone opcode fetch resets both ports to input, empty
    @(posedge clk);
    fetch_n <= 1'b0;
    repeat (2) @(posedge clk);
    fetch_n <= 1'b1;
    repeat (2) @(negedge clk);
    cmp_bit(rb, 1'b1);
    cmp_bit(ra, 1'b1);
    cmp_bit(pri_out, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
